// file: rtl/opaddr_gen.sv
// Operand address generator: fetches addressing bytes and forms the operand address
// Function
// - Short direct fetches one address byte, address stays inside 00 to FF.
// - Long direct fetches a two-byte address word, reaching all 64 Kbyte.
// - Indexed address is unsigned sum of chosen index register and offset.
// - No-offset indexed fetches nothing and uses the index register as address.
// - Short indexed fetches one offset byte; sum reaches up to 1FE.
// - Long indexed fetches a two-byte offset word plus index, full space.
// - Short indirect reads a byte pointer from page zero as the address.
// - Long indirect reads a page-zero word pointer used as full address.
// - Inherent instructions are only the opcode byte, no operand fetch.
// - Immediate instructions are two bytes; second byte is the operand itself.
// - Relative target is next-instruction PC plus signed offset, -128 to +127.
// - Read-modify-write memory instructions offer only short addressing forms.
// - Short direct and indirect forms stay in page zero; long forms reach whole space.
// - Y-select prebyte makes the following instruction use Y instead of X.
// - Indirect prebyte turns direct and offset X-indexed forms into indirect ones.
module opaddr_gen (
	input  wire logic              CLK,
	input  wire logic              SYS_RST,
	input  wire logic              START,
	input  wire logic [15:0]       PC_IN,
	input  wire logic [7:0]        X_IN,
	input  wire logic [7:0]        Y_IN,
	output logic      [15:0]       MEM_ADDR,
	output logic                   MEM_RD,
	input  wire logic [7:0]        MEM_DATA,
	input  wire logic              MEM_ACK,
	output logic                   BUSY,
	output logic                   DONE,
	output opaddr_pkg::res_t       RESULT
);

	opaddr_pkg::core_t core_r;
	opaddr_pkg::core_t core_nxt;
	opaddr_pkg::dec_t  dec;
	logic [7:0]        dec_op;
	logic [15:0]       idx_val;
	logic [15:0]       ea_val;
	logic [7:0]        rel_off;
	logic              got;

	// The decoder looks at the arriving byte while the opcode is on the bus
	assign dec_op = (core_r.st == opaddr_pkg::S_OPC) ? MEM_DATA : core_r.op;
	assign got    = MEM_RD & MEM_ACK;

	opaddr_mode_dec u_dec (
		.op      (dec_op),
		.pre_y   (core_r.pre_y),
		.pre_ind (core_r.pre_ind),
		.dec     (dec)
	);

	// Bus address: pointer reads go to page zero, all else walks the program stream
	always_comb begin
		MEM_ADDR = core_r.pc;
		MEM_RD   = 1'b0;
		case (core_r.st)
			opaddr_pkg::S_OPC, opaddr_pkg::S_B1, opaddr_pkg::S_B2, opaddr_pkg::S_REL: begin
				MEM_RD   = 1'b1;
			end
			opaddr_pkg::S_PLO: begin
				MEM_ADDR = {opaddr_pkg::PAGE0_HI, core_r.b1};
				MEM_RD   = 1'b1;
			end
			opaddr_pkg::S_PHI: begin
				// Pointer high byte wraps inside page zero
				MEM_ADDR = {opaddr_pkg::PAGE0_HI, core_r.b1 + opaddr_pkg::PTR_STEP};
				MEM_RD   = 1'b1;
			end
			default: begin
				MEM_RD   = 1'b0;
			end
		endcase
	end

	// Effective address per mode; index is zero-extended so sums stay unsigned
	always_comb begin
		idx_val = {opaddr_pkg::PAGE0_HI, (dec.use_y ? Y_IN : X_IN)};
		ea_val  = opaddr_pkg::RST_WORD;
		rel_off = (dec.mode == opaddr_pkg::M_REL_IND) ? core_r.p0 : core_r.rel;
		case (dec.mode)
			opaddr_pkg::M_DIR_SHORT, opaddr_pkg::M_BIT_DIR, opaddr_pkg::M_BITREL_DIR: begin
				ea_val = {opaddr_pkg::PAGE0_HI, core_r.b1};
			end
			opaddr_pkg::M_DIR_LONG: begin
				ea_val = {core_r.b1, core_r.b2};
			end
			opaddr_pkg::M_IDX_NONE: begin
				ea_val = idx_val;
			end
			opaddr_pkg::M_IDX_SHORT: begin
				ea_val = {opaddr_pkg::PAGE0_HI, core_r.b1} + idx_val;
			end
			opaddr_pkg::M_IDX_LONG: begin
				ea_val = {core_r.b1, core_r.b2} + idx_val;
			end
			opaddr_pkg::M_IND_SHORT, opaddr_pkg::M_BIT_IND, opaddr_pkg::M_BITREL_IND: begin
				ea_val = {opaddr_pkg::PAGE0_HI, core_r.p0};
			end
			opaddr_pkg::M_IND_LONG: begin
				ea_val = {core_r.p0, core_r.p1};
			end
			opaddr_pkg::M_INDIDX_SHORT: begin
				ea_val = {opaddr_pkg::PAGE0_HI, core_r.p0} + idx_val;
			end
			opaddr_pkg::M_INDIDX_LONG: begin
				ea_val = {core_r.p0, core_r.p1} + idx_val;
			end
			default: begin
				ea_val = opaddr_pkg::RST_WORD;
			end
		endcase
	end

	// Sequencer: prebytes, opcode, stream bytes, pointer, branch offset
	always_comb begin
		core_nxt      = core_r;
		core_nxt.done = 1'b0;
		case (core_r.st)
			opaddr_pkg::S_IDLE: begin
				if (START) begin
					core_nxt.st      = opaddr_pkg::S_OPC;
					core_nxt.pc      = PC_IN;
					core_nxt.len     = opaddr_pkg::RST_LEN;
					core_nxt.pre_y   = 1'b0;
					core_nxt.pre_ind = 1'b0;
				end
			end
			opaddr_pkg::S_OPC: begin
				if (got) begin
					core_nxt.pc  = core_r.pc + opaddr_pkg::PC_STEP;
					core_nxt.len = core_r.len + opaddr_pkg::LEN_ONE;
					// Only one prebyte is taken; a second one is treated as an opcode
					if (!(core_r.pre_y | core_r.pre_ind) &&
					    (MEM_DATA == opaddr_pkg::PRE_Y || MEM_DATA == opaddr_pkg::PRE_IND ||
					     MEM_DATA == opaddr_pkg::PRE_IND_Y)) begin
						core_nxt.pre_y   = (MEM_DATA != opaddr_pkg::PRE_IND);
						core_nxt.pre_ind = (MEM_DATA != opaddr_pkg::PRE_Y);
					end else begin
						core_nxt.op = MEM_DATA;
						if (dec.n_stream != 2'h0) begin
							core_nxt.st = opaddr_pkg::S_B1;
						end else if (dec.rel_tail) begin
							core_nxt.st = opaddr_pkg::S_REL;
						end else begin
							core_nxt.st = opaddr_pkg::S_DONE;
						end
					end
				end
			end
			opaddr_pkg::S_B1: begin
				if (got) begin
					core_nxt.b1  = MEM_DATA;
					core_nxt.pc  = core_r.pc + opaddr_pkg::PC_STEP;
					core_nxt.len = core_r.len + opaddr_pkg::LEN_ONE;
					if (dec.n_stream == 2'h2) begin
						core_nxt.st = opaddr_pkg::S_B2;
					end else if (dec.ptr != opaddr_pkg::PTR_NONE) begin
						core_nxt.st = opaddr_pkg::S_PLO;
					end else if (dec.rel_tail) begin
						core_nxt.st = opaddr_pkg::S_REL;
					end else begin
						core_nxt.st = opaddr_pkg::S_DONE;
					end
				end
			end
			opaddr_pkg::S_B2: begin
				if (got) begin
					core_nxt.b2  = MEM_DATA;
					core_nxt.pc  = core_r.pc + opaddr_pkg::PC_STEP;
					core_nxt.len = core_r.len + opaddr_pkg::LEN_ONE;
					core_nxt.st  = opaddr_pkg::S_DONE;
				end
			end
			opaddr_pkg::S_PLO: begin
				// Pointer reads do not advance the program stream
				if (got) begin
					core_nxt.p0 = MEM_DATA;
					if (dec.ptr == opaddr_pkg::PTR_WORD) begin
						core_nxt.st = opaddr_pkg::S_PHI;
					end else if (dec.rel_tail) begin
						core_nxt.st = opaddr_pkg::S_REL;
					end else begin
						core_nxt.st = opaddr_pkg::S_DONE;
					end
				end
			end
			opaddr_pkg::S_PHI: begin
				if (got) begin
					core_nxt.p1 = MEM_DATA;
					core_nxt.st = opaddr_pkg::S_DONE;
				end
			end
			opaddr_pkg::S_REL: begin
				if (got) begin
					core_nxt.rel = MEM_DATA;
					core_nxt.pc  = core_r.pc + opaddr_pkg::PC_STEP;
					core_nxt.len = core_r.len + opaddr_pkg::LEN_ONE;
					core_nxt.st  = opaddr_pkg::S_DONE;
				end
			end
			opaddr_pkg::S_DONE: begin
				// PC already points past the whole instruction here
				core_nxt.st           = opaddr_pkg::S_IDLE;
				core_nxt.done         = 1'b1;
				core_nxt.res.mode     = dec.mode;
				core_nxt.res.len      = core_r.len;
				core_nxt.res.use_y    = dec.use_y;
				core_nxt.res.ea       = ea_val;
				core_nxt.res.operand  = (dec.mode == opaddr_pkg::M_IMM) ?
				                        core_r.b1 : opaddr_pkg::RST_BYTE;
				core_nxt.res.target   = core_r.pc + {{8{rel_off[7]}}, rel_off};
				core_nxt.res.next_pc  = core_r.pc;
			end
			default: begin
				core_nxt.st = opaddr_pkg::S_IDLE;
			end
		endcase
	end

	// State register; reset clears the struct and sets the state to S_IDLE
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			core_r    <= '0;
			core_r.st <= opaddr_pkg::S_IDLE;
		end else begin
			core_r    <= core_nxt;
		end
	end

	assign BUSY   = (core_r.st != opaddr_pkg::S_IDLE);
	assign DONE   = core_r.done;
	assign RESULT = core_r.res;

endmodule

// file: rtl/opaddr_mode_dec.sv
// Opcode to addressing mode decoder, purely combinational
module opaddr_mode_dec (
	input  wire logic [7:0]        op,
	input  wire logic              pre_y,
	input  wire logic              pre_ind,
	output opaddr_pkg::dec_t       dec
);

	// Group decode on the high nibble, the indirect prebyte selects the counterpart
	always_comb begin
		dec           = '0;
		dec.mode      = opaddr_pkg::M_INH;
		dec.ptr       = opaddr_pkg::PTR_NONE;
		dec.use_y     = pre_y;
		case (op[7:4])
			opaddr_pkg::G_BTJ: begin
				dec.mode      = pre_ind ? opaddr_pkg::M_BITREL_IND : opaddr_pkg::M_BITREL_DIR;
				dec.n_stream  = 2'h1;
				dec.ptr       = pre_ind ? opaddr_pkg::PTR_BYTE : opaddr_pkg::PTR_NONE;
				dec.rel_tail  = 1'b1;
				dec.rmw_short = 1'b1;
			end
			opaddr_pkg::G_BIT: begin
				dec.mode      = pre_ind ? opaddr_pkg::M_BIT_IND : opaddr_pkg::M_BIT_DIR;
				dec.n_stream  = 2'h1;
				dec.ptr       = pre_ind ? opaddr_pkg::PTR_BYTE : opaddr_pkg::PTR_NONE;
				dec.rmw_short = 1'b1;
			end
			opaddr_pkg::G_REL: begin
				// Direct form takes its offset as the tail byte
				dec.mode      = pre_ind ? opaddr_pkg::M_REL_IND : opaddr_pkg::M_REL_DIR;
				dec.n_stream  = pre_ind ? 2'h1 : 2'h0;
				dec.ptr       = pre_ind ? opaddr_pkg::PTR_BYTE : opaddr_pkg::PTR_NONE;
				dec.rel_tail  = ~pre_ind;
			end
			opaddr_pkg::G_RMW_DIR, opaddr_pkg::G_DIR_S: begin
				dec.mode      = pre_ind ? opaddr_pkg::M_IND_SHORT : opaddr_pkg::M_DIR_SHORT;
				dec.n_stream  = 2'h1;
				dec.ptr       = pre_ind ? opaddr_pkg::PTR_BYTE : opaddr_pkg::PTR_NONE;
				dec.rmw_short = (op[7:4] == opaddr_pkg::G_RMW_DIR);
			end
			opaddr_pkg::G_RMW_IX1, opaddr_pkg::G_IX1: begin
				dec.mode      = pre_ind ? opaddr_pkg::M_INDIDX_SHORT : opaddr_pkg::M_IDX_SHORT;
				dec.n_stream  = 2'h1;
				dec.ptr       = pre_ind ? opaddr_pkg::PTR_BYTE : opaddr_pkg::PTR_NONE;
				dec.idx       = 1'b1;
				dec.rmw_short = (op[7:4] == opaddr_pkg::G_RMW_IX1);
			end
			opaddr_pkg::G_RMW_IX0, opaddr_pkg::G_IX0: begin
				dec.mode      = opaddr_pkg::M_IDX_NONE;
				dec.idx       = 1'b1;
				dec.rmw_short = (op[7:4] == opaddr_pkg::G_RMW_IX0);
			end
			opaddr_pkg::G_IMM: begin
				dec.mode      = opaddr_pkg::M_IMM;
				dec.n_stream  = 2'h1;
			end
			opaddr_pkg::G_DIR_L: begin
				// Long indirect keeps a one-byte pointer address
				dec.mode      = pre_ind ? opaddr_pkg::M_IND_LONG : opaddr_pkg::M_DIR_LONG;
				dec.n_stream  = pre_ind ? 2'h1 : 2'h2;
				dec.ptr       = pre_ind ? opaddr_pkg::PTR_WORD : opaddr_pkg::PTR_NONE;
			end
			opaddr_pkg::G_IX2: begin
				dec.mode      = pre_ind ? opaddr_pkg::M_INDIDX_LONG : opaddr_pkg::M_IDX_LONG;
				dec.n_stream  = pre_ind ? 2'h1 : 2'h2;
				dec.ptr       = pre_ind ? opaddr_pkg::PTR_WORD : opaddr_pkg::PTR_NONE;
				dec.idx       = 1'b1;
			end
			default: begin
				dec.mode      = opaddr_pkg::M_INH;
			end
		endcase
	end

endmodule

// file: rtl/opaddr_pkg.sv
// Shared types and constants for the operand address generator
package opaddr_pkg;

	// Addressing modes, one code per documented mode
	typedef enum logic [4:0] {
		M_INH          = 5'h00,
		M_IMM          = 5'h01,
		M_DIR_SHORT    = 5'h02,
		M_DIR_LONG     = 5'h03,
		M_IDX_NONE     = 5'h04,
		M_IDX_SHORT    = 5'h05,
		M_IDX_LONG     = 5'h06,
		M_IND_SHORT    = 5'h07,
		M_IND_LONG     = 5'h08,
		M_INDIDX_SHORT = 5'h09,
		M_INDIDX_LONG  = 5'h0a,
		M_REL_DIR      = 5'h0b,
		M_REL_IND      = 5'h0c,
		M_BIT_DIR      = 5'h0d,
		M_BIT_IND      = 5'h0e,
		M_BITREL_DIR   = 5'h0f,
		M_BITREL_IND   = 5'h10
	} mode_t;

	// Size of the page-zero pointer read after the address byte
	typedef enum logic [1:0] {
		PTR_NONE = 2'h0,
		PTR_BYTE = 2'h1,
		PTR_WORD = 2'h2
	} ptr_t;

	// Decoded addressing information for one opcode
	typedef struct packed {
		mode_t      mode;
		logic [1:0] n_stream;
		ptr_t       ptr;
		logic       idx;
		logic       rel_tail;
		logic       use_y;
		logic       rmw_short;
	} dec_t;

	// Sequencer states, one-hot
	typedef enum logic [7:0] {
		S_IDLE = 8'h01,
		S_OPC  = 8'h02,
		S_B1   = 8'h04,
		S_B2   = 8'h08,
		S_PLO  = 8'h10,
		S_PHI  = 8'h20,
		S_REL  = 8'h40,
		S_DONE = 8'h80
	} state_t;

	// Result handed to the execution stage
	typedef struct packed {
		mode_t       mode;
		logic [2:0]  len;
		logic        use_y;
		logic [15:0] ea;
		logic [7:0]  operand;
		logic [15:0] target;
		logic [15:0] next_pc;
	} res_t;

	// Whole state of the sequencer
	typedef struct packed {
		state_t      st;
		logic [15:0] pc;
		logic [2:0]  len;
		logic        pre_y;
		logic        pre_ind;
		logic [7:0]  op;
		logic [7:0]  b1;
		logic [7:0]  b2;
		logic [7:0]  p0;
		logic [7:0]  p1;
		logic [7:0]  rel;
		logic        done;
		res_t        res;
	} core_t;

	// Prebyte codes
	localparam logic [7:0] PRE_Y     = 8'h90;
	localparam logic [7:0] PRE_IND_Y = 8'h91;
	localparam logic [7:0] PRE_IND   = 8'h92;

	// Opcode groups by high nibble
	localparam logic [3:0] G_BTJ     = 4'h0;
	localparam logic [3:0] G_BIT     = 4'h1;
	localparam logic [3:0] G_REL     = 4'h2;
	localparam logic [3:0] G_RMW_DIR = 4'h3;
	localparam logic [3:0] G_RMW_IX1 = 4'h6;
	localparam logic [3:0] G_RMW_IX0 = 4'h7;
	localparam logic [3:0] G_IMM     = 4'ha;
	localparam logic [3:0] G_DIR_S   = 4'hb;
	localparam logic [3:0] G_DIR_L   = 4'hc;
	localparam logic [3:0] G_IX2     = 4'hd;
	localparam logic [3:0] G_IX1     = 4'he;
	localparam logic [3:0] G_IX0     = 4'hf;

	// Page-zero high byte and reset values
	localparam logic [7:0]  PAGE0_HI  = 8'h00;
	localparam logic [15:0] RST_PC    = 16'h0000;
	localparam logic [2:0]  RST_LEN   = 3'h0;
	localparam logic [7:0]  RST_BYTE  = 8'h00;
	localparam logic [15:0] RST_WORD  = 16'h0000;
	localparam logic [2:0]  LEN_ONE   = 3'h1;
	localparam logic [15:0] PC_STEP   = 16'h0001;
	localparam logic [7:0]  PTR_STEP  = 8'h01;

endpackage

// file: verif/opaddr_gen_properties.sv
// Concurrent checks on the ports of the operand address generator
module opaddr_gen_properties (
	input  wire logic              CLK,
	input  wire logic              SYS_RST,
	input  wire logic              START,
	input  wire logic [15:0]       PC_IN,
	input  wire logic [7:0]        X_IN,
	input  wire logic [7:0]        Y_IN,
	input  wire logic [15:0]       MEM_ADDR,
	input  wire logic              MEM_RD,
	input  wire logic [7:0]        MEM_DATA,
	input  wire logic              MEM_ACK,
	input  wire logic              BUSY,
	input  wire logic              DONE,
	input  wire opaddr_pkg::res_t  RESULT
);
	logic [15:0] pc_r;
	logic [7:0]  last_r;
	logic [7:0]  prev_r;
	logic [2:0]  acks_r;

	default clocking cb @(posedge CLK); endclocking
	default disable iff (SYS_RST);

	// Remember start address and the last two bytes read, and count reads per instruction
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			pc_r   <= 16'h0000;
			last_r <= 8'h00;
			prev_r <= 8'h00;
			acks_r <= 3'h0;
		end else if (START && !BUSY) begin
			pc_r   <= PC_IN;
			acks_r <= 3'h0;
		end else if (MEM_RD && MEM_ACK) begin
			prev_r <= last_r;
			last_r <= MEM_DATA;
			acks_r <= acks_r + 3'h1;
		end
	end

	property p_req_hold;
		MEM_RD && !MEM_ACK |=> MEM_RD && $stable(MEM_ADDR);
	endproperty
	a_req_hold: assert property (p_req_hold) else $error("read moved before ack");
	property p_take;
		START && !BUSY |=> BUSY && !DONE ##1 !DONE ##[1:60] DONE;
	endproperty
	a_take: assert property (p_take) else $error("start not taken properly");
	property p_done_pulse;
		DONE |=> !DONE;
	endproperty
	a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");
	property p_len;
		DONE |-> RESULT.next_pc == pc_r + {13'h0000, RESULT.len};
	endproperty
	a_len: assert property (p_len) else $error("next address wrong");
	property p_inh;
		DONE && RESULT.mode == opaddr_pkg::M_INH |-> acks_r == RESULT.len;
	endproperty
	a_inh: assert property (p_inh) else $error("inherent fetched operands");
	property p_imm;
		DONE && RESULT.mode == opaddr_pkg::M_IMM |-> RESULT.operand == last_r;
	endproperty
	a_imm: assert property (p_imm) else $error("immediate operand wrong");
	property p_dir_s;
		DONE && RESULT.mode == opaddr_pkg::M_DIR_SHORT |-> RESULT.ea == {8'h00, last_r};
	endproperty
	a_dir_s: assert property (p_dir_s) else $error("short direct address wrong");
	property p_dir_l;
		DONE && RESULT.mode == opaddr_pkg::M_DIR_LONG |-> RESULT.ea == {prev_r, last_r};
	endproperty
	a_dir_l: assert property (p_dir_l) else $error("long direct address wrong");
	property p_ind_s;
		DONE && RESULT.mode == opaddr_pkg::M_IND_SHORT |-> RESULT.ea == {8'h00, last_r};
	endproperty
	a_ind_s: assert property (p_ind_s) else $error("short indirect address wrong");
	property p_idx0;
		// Index registers count in the cycle before DONE, chosen by the new result's use_y
		DONE && RESULT.mode == opaddr_pkg::M_IDX_NONE
			|-> RESULT.ea == {8'h00, (RESULT.use_y ? $past(Y_IN) : $past(X_IN))};
	endproperty
	a_idx0: assert property (p_idx0) else $error("no-offset index wrong");
	property p_idx_s;
		DONE && RESULT.mode == opaddr_pkg::M_IDX_SHORT
			|-> RESULT.ea == {8'h00, last_r} + {8'h00, (RESULT.use_y ? $past(Y_IN) : $past(X_IN))};
	endproperty
	a_idx_s: assert property (p_idx_s) else $error("short indexed sum wrong");
	property p_rel;
		DONE && RESULT.mode inside {opaddr_pkg::M_REL_DIR, opaddr_pkg::M_BITREL_DIR}
			|-> RESULT.target == RESULT.next_pc + {{8{last_r[7]}}, last_r};
	endproperty
	a_rel: assert property (p_rel) else $error("branch target wrong");
endmodule

bind opaddr_gen opaddr_gen_properties u_opaddr_gen_properties (
	.CLK(CLK), .SYS_RST(SYS_RST), .START(START), .PC_IN(PC_IN), .X_IN(X_IN),
	.Y_IN(Y_IN), .MEM_ADDR(MEM_ADDR), .MEM_RD(MEM_RD), .MEM_DATA(MEM_DATA),
	.MEM_ACK(MEM_ACK), .BUSY(BUSY), .DONE(DONE), .RESULT(RESULT)
);

// file: verif/opaddr_mem_model.sv
// Behavioural program and data memory answering reads after a varying delay
module opaddr_mem_model (
	input  wire logic        clk,
	input  wire logic [15:0] addr,
	input  wire logic        rd,
	input  wire logic [2:0]  max_wait,
	output logic      [7:0]  data,
	output logic             ack
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem [0:65535];
	int         wait_cnt = 0;
	int         turn = 0;

	// Cleared contents so bytes past a shifted instruction never read unknown
	initial begin
		data = 8'h00;
		ack  = 1'b0;
		for (int i = 0; i < 65536; i++)
			mem[i] = 8'h00;
	end

	// Delay cycles through 0..max_wait so prompt and slow reads both occur;
	// outside an answer the data line toggles so a stale sample shows up wrong
	always @(negedge clk) begin
		if (rd && wait_cnt == 0) begin
			ack      <= 1'b1;
			data     <= mem[addr];
			turn     = turn + 1;
			wait_cnt = turn % (max_wait + 1);
		end else begin
			ack  <= 1'b0;
			data <= ~data;
			if (rd)
				wait_cnt = wait_cnt - 1;
		end
	end
endmodule

// file: verif/operand_address_generator_tb.sv
// Self-checking bench for the operand address generator with a memory partner
module operand_address_generator_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic             CLK;
	logic             SYS_RST;
	logic             START;
	logic [15:0]      PC_IN;
	logic [7:0]       X_IN;
	logic [7:0]       Y_IN;
	logic [15:0]      MEM_ADDR;
	logic             MEM_RD;
	logic [7:0]       MEM_DATA;
	logic             MEM_ACK;
	logic             BUSY;
	logic             DONE;
	opaddr_pkg::res_t RESULT;
	logic [2:0]       max_wait;
	int               seed = 68;
	int               fails = 0;
	int               samples_checked = 0;
	logic [7:0]       pre_tab [4] = '{8'h00, 8'h90, 8'h91, 8'h92};

	opaddr_gen u_opaddr_gen (.CLK(CLK), .SYS_RST(SYS_RST), .START(START), .PC_IN(PC_IN),
		.X_IN(X_IN), .Y_IN(Y_IN), .MEM_ADDR(MEM_ADDR), .MEM_RD(MEM_RD), .MEM_DATA(MEM_DATA),
		.MEM_ACK(MEM_ACK), .BUSY(BUSY), .DONE(DONE), .RESULT(RESULT));
	opaddr_mem_model u_opaddr_mem_model (.clk(CLK), .addr(MEM_ADDR), .rd(MEM_RD),
		.max_wait(max_wait), .data(MEM_DATA), .ack(MEM_ACK));

	// 50 ns clock
	initial begin
		CLK = 1'b0;
		forever #25 CLK = ~CLK;
	end

	function automatic logic [7:0] rb();
		return 8'($random(seed));
	endfunction

	function automatic logic [7:0] mem_at(input logic [15:0] a);
		return u_opaddr_mem_model.mem[a];
	endfunction

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, seen);
		end
	endtask

	task automatic end_of_test;
		$display("comparisons %0d, mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Reference decode from the instruction bytes now in memory
	task automatic predict(input logic [15:0] pc, output opaddr_pkg::res_t e,
		output bit ce, output bit ct);
		logic [7:0]  o, b1, b2, p, ix, ofs;
		logic [15:0] pw;
		bit          y, ind;
		int          n, s;
		o = mem_at(pc);
		n = (o inside {8'h90, 8'h91, 8'h92});
		y = n && o != 8'h92;
		ind = n && o != 8'h90;
		o = mem_at(pc + 16'(n));
		b1 = mem_at(pc + 16'(n + 1));
		b2 = mem_at(pc + 16'(n + 2));
		p = mem_at({8'h00, b1});
		pw = {p, mem_at({8'h00, 8'(b1 + 8'h01)})};
		ix = y ? Y_IN : X_IN;
		e = '0;
		ce = 1;
		ct = 0;
		s = 1;
		ofs = ind ? p : b1;
		case (o[7:4])
			4'ha: begin
				e.mode = opaddr_pkg::M_IMM;
				e.operand = b1;
				ce = 0;
			end
			4'hb, 4'h3: begin
				e.mode = ind ? opaddr_pkg::M_IND_SHORT : opaddr_pkg::M_DIR_SHORT;
				e.ea = {8'h00, ofs};
			end
			4'hc: begin
				e.mode = ind ? opaddr_pkg::M_IND_LONG : opaddr_pkg::M_DIR_LONG;
				s = ind ? 1 : 2;
				e.ea = ind ? pw : {b1, b2};
			end
			4'hd: begin
				e.mode = ind ? opaddr_pkg::M_INDIDX_LONG : opaddr_pkg::M_IDX_LONG;
				s = ind ? 1 : 2;
				e.ea = (ind ? pw : {b1, b2}) + {8'h00, ix};
			end
			4'he, 4'h6: begin
				e.mode = ind ? opaddr_pkg::M_INDIDX_SHORT : opaddr_pkg::M_IDX_SHORT;
				e.ea = {8'h00, ofs} + {8'h00, ix};
			end
			4'hf, 4'h7: begin
				e.mode = opaddr_pkg::M_IDX_NONE;
				s = 0;
				e.ea = {8'h00, ix};
			end
			4'h2: begin
				e.mode = ind ? opaddr_pkg::M_REL_IND : opaddr_pkg::M_REL_DIR;
				ce = 0;
				ct = 1;
			end
			4'h1: begin
				e.mode = ind ? opaddr_pkg::M_BIT_IND : opaddr_pkg::M_BIT_DIR;
				e.ea = {8'h00, ofs};
			end
			4'h0: begin
				e.mode = ind ? opaddr_pkg::M_BITREL_IND : opaddr_pkg::M_BITREL_DIR;
				e.ea = {8'h00, ofs};
				s = 2;
				ofs = b2;
				ct = 1;
			end
			default: begin
				e.mode = opaddr_pkg::M_INH;
				s = 0;
				ce = 0;
			end
		endcase
		e.len = 3'(n + 1 + s);
		e.use_y = y;
		e.next_pc = pc + {13'h0000, e.len};
		e.target = e.next_pc + {{8{ofs[7]}}, ofs};
	endtask

	// One instruction; START stays up a second cycle with a wrong address, which must be ignored
	task automatic run_one(input logic [15:0] pc, input logic [7:0] pre, op, b1, b2, x, y);
		opaddr_pkg::res_t e;
		bit               ce, ct;
		int               n;
		n = (pre != 8'h00);
		u_opaddr_mem_model.mem[pc] = pre;
		u_opaddr_mem_model.mem[pc + 16'(n)] = op;
		u_opaddr_mem_model.mem[pc + 16'(n + 1)] = b1;
		u_opaddr_mem_model.mem[pc + 16'(n + 2)] = b2;
		u_opaddr_mem_model.mem[{8'h00, b1}] = rb();
		u_opaddr_mem_model.mem[{8'h00, 8'(b1 + 8'h01)}] = rb();
		START = 1'b1;
		PC_IN = pc;
		X_IN = x;
		Y_IN = y;
		predict(pc, e, ce, ct);
		@(negedge CLK);
		PC_IN = pc + 16'h0005;
		@(negedge CLK);
		START = 1'b0;
		for (int i = 0; i < 60 && DONE !== 1'b1; i++)
			@(negedge CLK);
		check("done", {31'h0, DONE}, 32'h1);
		check("mode", RESULT.mode, e.mode);
		check("len", RESULT.len, e.len);
		check("use_y", RESULT.use_y, e.use_y);
		check("operand", RESULT.operand, e.operand);
		check("next_pc", RESULT.next_pc, e.next_pc);
		if (ce)
			check("ea", RESULT.ea, e.ea);
		if (ct)
			check("target", RESULT.target, e.target);
	endtask

	// Watchdog: the run needs well under a millisecond
	initial begin
		#3000000;
		fails++;
		end_of_test();
	end

	initial begin
		SYS_RST = 1'b1;
		START = 1'b0;
		PC_IN = 16'h0000;
		X_IN = 8'h00;
		Y_IN = 8'h00;
		max_wait = 3'h0;
		repeat (4) @(posedge CLK);
		@(negedge CLK);
		SYS_RST = 1'b0;
		check("idle", {13'h0000, BUSY, DONE, MEM_RD, MEM_ADDR}, 32'h0);
		check("idle_result", {31'h0, |RESULT}, 32'h0);
		// Every opcode group under each prebyte; max_wait follows the prebyte slot, so unprefixed opcodes get prompt memory only
		for (int r = 0; r < 4; r++) begin
			for (int k = 0; k < 64; k++) begin
				max_wait = 3'(k % 4);
				run_one({4'(r + 1), 4'(k), rb()}, pre_tab[k % 4], {4'(k / 4), 4'(rb())},
					rb(), rb(), rb(), rb());
			end
		end
		$display("test sweep done");
		// Boundary values: 1FE sums, offsets -128 and +127, pointer and 64K wrap
		max_wait = 3'h3;
		run_one(16'h6000, 8'h00, 8'he5, 8'hff, 8'h00, 8'hff, 8'h00);
		run_one(16'h6010, 8'h90, 8'h65, 8'hff, 8'h00, 8'h00, 8'hff);
		run_one(16'h6020, 8'h00, 8'h27, 8'h80, 8'h00, rb(), rb());
		run_one(16'h6030, 8'h00, 8'h07, 8'h40, 8'h7f, rb(), rb());
		max_wait = 3'h0;
		run_one(16'h6040, 8'h92, 8'hc6, 8'hff, 8'h00, rb(), rb());
		run_one(16'h6050, 8'h00, 8'hd6, 8'hff, 8'hff, 8'h02, 8'h00);
		run_one(16'h6060, 8'h91, 8'hd6, 8'hff, 8'h00, 8'h00, 8'hff);
		$display("test edges done");
		end_of_test();
	end
endmodule
